// ==== verilog/plm_pkg.sv ====
/*
  Constants for the PCM level meter: command codes, field positions,
  reset values, frame timing and meter states.
  Assumes a 50 MHz system clock and 16-bit linear PCM samples.
*/
package plm_pkg;

  // ==========================================================
  // Command byte layout
  localparam int unsigned CMD_WRITE_BIT = 7;
  localparam logic [6:0]  ADDR_WIN_LOW  = 7'h2e;
  localparam logic [6:0]  ADDR_CTRL     = 7'h2f;
  localparam logic [6:0]  ADDR_RES_LOW  = 7'h30;
  localparam logic [6:0]  ADDR_RES_HIGH = 7'h31;

  // ==========================================================
  // Control register fields
  localparam int unsigned CTRL_SINGLE_BIT = 7;
  localparam int unsigned CTRL_ENABLE_BIT = 6;
  localparam int unsigned CTRL_CS_MSB     = 5;
  localparam int unsigned CTRL_CS_LSB     = 4;
  localparam int unsigned CTRL_CNT_MSB    = 2;
  localparam int unsigned CTRL_CNT_LSB    = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  WIN_LOW_RESET = 8'h00;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [15:0] RESULT_RESET  = 16'h0000;

  // ==========================================================
  // Window and frame timing
  localparam int unsigned WIN_W          = 11;
  localparam logic [10:0] WIN_MAX        = 11'h7ff;
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned FRAME_NS       = 125000;
  localparam int unsigned FRAME_CYCLES   = FRAME_NS / CLK_PERIOD_NS;
  localparam int unsigned PCM_W          = 16;

  // ==========================================================
  // Meter states
  typedef enum logic [1:0] {
    PLM_IDLE = 2'b00,
    PLM_RUN  = 2'b01,
    PLM_HOLD = 2'b10
  } plm_state_t;

endpackage

// ==== verilog/plm_frame_div.sv ====
/*
  Frame divider: one-cycle enable pulse every FRAME_CYCLES clocks.
  Assumes a single free-running clock; restarts while clear is high.
*/
`timescale 1ns/100ps
module plm_frame_div #(
  parameter int unsigned FRAME_CYCLES = plm_pkg::FRAME_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Control
  input  wire logic clear,
  // Frame enable
  output logic      frame_tick
);

  // ==========================================================
  // Divider
  logic [15:0] div_ff;
  logic [15:0] nxt_div;
  logic        wrap;

  assign wrap    = (div_ff == 16'(FRAME_CYCLES - 1));
  assign nxt_div = (clear || wrap) ? 16'h0000 : div_ff + 16'h0001;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_ff     <= 16'h0000;
      frame_tick <= 1'b0;
    end else begin
      div_ff     <= nxt_div;
      frame_tick <= wrap && !clear;
    end
  end

endmodule

// ==== verilog/plm_level_meter.sv ====
/*
  PCM level meter: picks one of four PCM channels, tracks the peak
  magnitude over a window of 125 us frames and reports it as two
  read-only result bytes reached through host command bytes.
  Assumes PCM inputs come from logic on the same clock and hold a
  sample per frame; commands arrive as one-cycle strobes.
*/
// Summary of operation
// - Window count joins low byte and control bits
// - Window in 0.125 ms steps up to 7FFH
// - Zero count passes PCM straight to results
// - Count N samples over N frames
// - Result low byte read-only, resets zero
// - Result high byte read-only, resets zero
// - Result bytes read by 30H and 31H only
// - Count 2EH/AEH, control 2FH/AFH, bit7 writes
`timescale 1ns/100ps
module plm_level_meter #(
  parameter int unsigned FRAME_CYCLES = plm_pkg::FRAME_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Host command port
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic [7:0]  cmd_wdata,
  output logic [7:0]       rd_data,
  output logic             rd_valid,
  // PCM channel data
  input  wire logic [15:0] pcm_ch1,
  input  wire logic [15:0] pcm_ch2,
  input  wire logic [15:0] pcm_ch3,
  input  wire logic [15:0] pcm_ch4,
  // Meter status
  output logic             meter_running
);

  // ==========================================================
  // Registers
  logic [7:0]               win_low_ff;
  logic [7:0]               ctrl_ff;
  logic [15:0]              result_ff;
  logic [15:0]              peak_ff;
  logic [10:0]              frame_cnt_ff;
  plm_pkg::plm_state_t      state_ff;
  plm_pkg::plm_state_t      nxt_state;
  logic [7:0]               rd_data_ff;
  logic                     rd_valid_ff;
  logic                     running_ff;

  // ==========================================================
  // Command decode
  wire        cmd_write    = cmd_byte[plm_pkg::CMD_WRITE_BIT];
  wire [6:0]  cmd_addr     = cmd_byte[6:0];
  wire        wr_win_low   = cmd_valid && cmd_write && (cmd_addr == plm_pkg::ADDR_WIN_LOW);
  wire        wr_ctrl      = cmd_valid && cmd_write && (cmd_addr == plm_pkg::ADDR_CTRL);
  wire        rd_cmd       = cmd_valid && !cmd_write;
  wire        cfg_write    = wr_win_low || wr_ctrl;

  // ==========================================================
  // Control fields
  wire        single_shot          = ctrl_ff[plm_pkg::CTRL_SINGLE_BIT];
  wire        meter_enable         = ctrl_ff[plm_pkg::CTRL_ENABLE_BIT];
  wire [1:0]  meter_channel_select = ctrl_ff[plm_pkg::CTRL_CS_MSB:plm_pkg::CTRL_CS_LSB];
  wire [10:0] window_count         = {ctrl_ff[plm_pkg::CTRL_CNT_MSB:plm_pkg::CTRL_CNT_LSB], win_low_ff};
  wire        window_zero          = (window_count == 11'h000);

  // ==========================================================
  // Channel selection and magnitude
  wire [15:0] pcm_in  [4];
  wire [15:0] ch_term [4];

  assign pcm_in[0] = pcm_ch1;
  assign pcm_in[1] = pcm_ch2;
  assign pcm_in[2] = pcm_ch3;
  assign pcm_in[3] = pcm_ch4;

  for (genvar ch = 0; ch < 4; ch++) begin : g_chan
    wire ch_hit = (meter_channel_select == 2'(ch));
    assign ch_term[ch] = ch_hit ? pcm_in[ch] : 16'h0000;
  end

  wire [15:0] pcm_sel = ch_term[0] | ch_term[1] | ch_term[2] | ch_term[3];

  wire [15:0] pcm_mag  = pcm_sel[15] ? (16'h0000 - pcm_sel) : pcm_sel;
  wire [15:0] peak_new = (pcm_mag > peak_ff) ? pcm_mag : peak_ff;

  // ==========================================================
  // Frame enable
  logic frame_tick;

  plm_frame_div #(
    .FRAME_CYCLES (FRAME_CYCLES)
  ) u_frame_div (
    .clk        (clk),
    .reset      (reset),
    .clear      (cfg_write),
    .frame_tick (frame_tick)
  );

  // ==========================================================
  // Window progress
  wire        in_run      = (state_ff == plm_pkg::PLM_RUN);
  wire        window_last = (frame_cnt_ff == (window_count - 11'h001));
  wire        run_tick    = in_run && frame_tick && !window_zero;
  wire        window_end  = run_tick && window_last;
  wire        pass_tick   = in_run && frame_tick && window_zero;

  // ==========================================================
  // State machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      plm_pkg::PLM_IDLE: begin
        if (meter_enable && !cfg_write) begin
          nxt_state = plm_pkg::PLM_RUN;
        end
      end
      plm_pkg::PLM_RUN: begin
        if (!meter_enable || cfg_write) begin
          nxt_state = plm_pkg::PLM_IDLE;
        end else if (window_end && single_shot) begin
          nxt_state = plm_pkg::PLM_HOLD;
        end
      end
      plm_pkg::PLM_HOLD: begin
        if (!meter_enable || !single_shot || cfg_write) begin
          nxt_state = plm_pkg::PLM_IDLE;
        end
      end
      default: nxt_state = plm_pkg::PLM_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff   <= plm_pkg::PLM_IDLE;
      running_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      running_ff <= (nxt_state == plm_pkg::PLM_RUN);
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      win_low_ff <= plm_pkg::WIN_LOW_RESET;
      ctrl_ff    <= plm_pkg::CTRL_RESET;
    end else begin
      if (wr_win_low) begin
        win_low_ff <= cmd_wdata;
      end
      if (wr_ctrl) begin
        ctrl_ff <= {cmd_wdata[7:4], 1'b0, cmd_wdata[2:0]};
      end
    end
  end

  // ==========================================================
  // Window counter
  wire [10:0] nxt_frame_cnt = (!in_run || window_end) ? 11'h000 :
                              run_tick ? frame_cnt_ff + 11'h001 : frame_cnt_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame_cnt_ff <= 11'h000;
    end else begin
      frame_cnt_ff <= nxt_frame_cnt;
    end
  end

  // ==========================================================
  // Peak tracker and result
  wire [15:0] nxt_peak      = (!in_run || window_end) ? 16'h0000 :
                              run_tick ? peak_new : peak_ff;
  wire [15:0] nxt_result    = pass_tick  ? pcm_sel :
                              window_end ? peak_new : result_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      peak_ff   <= 16'h0000;
      result_ff <= plm_pkg::RESULT_RESET;
    end else begin
      peak_ff   <= nxt_peak;
      result_ff <= nxt_result;
    end
  end

  // ==========================================================
  // Read path
  logic [7:0] rd_mux;
  always_comb begin
    case (cmd_addr)
      plm_pkg::ADDR_WIN_LOW:  rd_mux = win_low_ff;
      plm_pkg::ADDR_CTRL:     rd_mux = ctrl_ff;
      plm_pkg::ADDR_RES_LOW:  rd_mux = result_ff[7:0];
      plm_pkg::ADDR_RES_HIGH: rd_mux = result_ff[15:8];
      default:                rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_cmd;
      if (rd_cmd) begin
        rd_data_ff <= rd_mux;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign rd_data       = rd_data_ff;
  assign rd_valid      = rd_valid_ff;
  assign meter_running = running_ff;

endmodule

// ==== bench/plm_level_meter_assertions.sv ====
/*
  Checker for the level meter host port and run status.
  Bound to plm_level_meter; sees only its ports.
*/
`timescale 1ns/100ps
module plm_level_meter_chk #(
  parameter int unsigned FRAME_CYCLES = 8
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Host port
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_byte,
  input wire logic [7:0]  cmd_wdata,
  input wire logic [7:0]  rd_data,
  input wire logic        rd_valid,
  // PCM and status
  input wire logic [15:0] pcm_ch1,
  input wire logic [15:0] pcm_ch2,
  input wire logic [15:0] pcm_ch3,
  input wire logic [15:0] pcm_ch4,
  input wire logic        meter_running
);
  logic rd_cmd;
  logic ctl_wr;
  assign rd_cmd = cmd_valid && !cmd_byte[7];
  assign ctl_wr = cmd_valid && cmd_byte == 8'haf;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // Command port
  property p_rd_answer; rd_cmd |=> rd_valid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_hold; !rd_cmd |=> $stable(rd_data); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_unmapped; rd_cmd && (cmd_byte[6:0] < 7'h2e || cmd_byte[6:0] > 7'h31) |=> rd_data == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rsvd; rd_cmd && cmd_byte[6:0] == 7'h2f |=> !rd_data[3]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_wr_quiet; cmd_valid && cmd_byte[7] |=> !rd_valid; endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("write answered");
  property p_rd_cause; rd_valid |-> $past(rd_cmd); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("spurious read answer");
  // ==========================================================
  // Meter run status
  property p_run_off; ctl_wr && !cmd_wdata[6] ##1 !cmd_valid |=> !meter_running; endproperty
  a_run_off: assert property (p_run_off) else $error("meter runs while off");
  property p_run_on; ctl_wr && cmd_wdata[7:6] == 2'b01 ##1 !cmd_valid [*8] |=> meter_running; endproperty
  a_run_on: assert property (p_run_on) else $error("continuous meter stopped");
endmodule
bind plm_level_meter plm_level_meter_chk #(.FRAME_CYCLES(FRAME_CYCLES)) chk_u (
  .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_wdata(cmd_wdata),
  .rd_data(rd_data), .rd_valid(rd_valid), .pcm_ch1(pcm_ch1), .pcm_ch2(pcm_ch2), .pcm_ch3(pcm_ch3),
  .pcm_ch4(pcm_ch4), .meter_running(meter_running));

// ==== bench/pcm_level_meter_bench.sv ====
/*
  Self-checking bench for the level meter.
  Drives host commands and PCM inputs itself; frames shortened to 8 clocks.
*/
`timescale 1ns/100ps
module pcm_level_meter_bench;
  // ==========================================================
  // Signals
  localparam int FC = 8;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        cmd_valid = 1'b0;
  logic [7:0]  cmd_byte = 8'h00;
  logic [7:0]  cmd_wdata = 8'h00;
  logic [15:0] pcm [4] = '{4{16'h0000}};
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        meter_running;
  logic [15:0] rnd = 16'h81ff;
  logic [15:0] got;
  logic [15:0] last;
  int          error_cnt = 0;
  int          cmp_count = 0;
  always #10 clk = ~clk;
  plm_level_meter #(.FRAME_CYCLES(FC)) dut_u (
    .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_wdata(cmd_wdata),
    .rd_data(rd_data), .rd_valid(rd_valid), .pcm_ch1(pcm[0]), .pcm_ch2(pcm[1]), .pcm_ch3(pcm[2]),
    .pcm_ch4(pcm[3]), .meter_running(meter_running));
  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] mag(input logic [15:0] s);
    return s[15] ? 16'h0000 - s : s;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] wd);
    cmd_valid <= 1'b1;
    cmd_byte <= op;
    cmd_wdata <= wd;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1 got = {7'h00, rd_valid, rd_data};
    @(posedge clk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    cmd({1'b0, a}, 8'h00);
    check(got, {8'h01, exp});
  endtask
  task automatic res(input logic [15:0] exp);
    rd(7'h30, exp[7:0]);
    rd(7'h31, exp[15:8]);
  endtask
  task automatic win(input int n, input logic [15:0] val);
    pcm[1] <= val;
    cmd(8'hae, n[7:0]);
    cmd(8'haf, {5'b01010, n[10:8]});
    repeat (n * FC - 8) @(posedge clk);
    res(last);
    repeat (10) @(posedge clk);
    last = mag(val);
    res(last);
    $display("test window %0d done", n);
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check({15'h0000, meter_running}, 16'h0000);
    for (int a = 'h2e; a <= 'h31; a++) rd(a[6:0], 8'h00);
    rd(7'h7f, 8'h00);
    rnd = lfsr(rnd);
    cmd(8'hae, rnd[7:0]);
    rd(7'h2e, rnd[7:0]);
    cmd(8'haf, rnd[15:8] & 8'h3f);
    rd(7'h2f, rnd[15:8] & 8'h37);
    cmd(8'hb2, 8'h5a);
    res(16'h0000);
    $display("test registers done");
    cmd(8'hae, 8'h00);
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        rnd = lfsr(rnd);
        pcm[k] <= rnd;
      end
      cmd(8'haf, {2'b01, c[1:0], 4'h0});
      repeat (FC + 2) @(posedge clk);
      last = pcm[c];
      res(last);
    end
    $display("test transparent done");
    win(3, 16'h8000);
    rnd = lfsr(rnd);
    win(1, rnd);
    win(2047, rnd | 16'h8000);
    rnd = lfsr(rnd);
    pcm[1] <= rnd;
    cmd(8'hae, 8'h01);
    cmd(8'haf, 8'hd0);
    repeat (2 * FC + 4) @(posedge clk);
    last = mag(rnd);
    pcm[1] <= 16'hc001;
    repeat (3 * FC) @(posedge clk);
    res(last);
    check({15'h0000, meter_running}, 16'h0000);
    cmd(8'haf, 8'h50);
    repeat (2 * FC) @(posedge clk);
    last = 16'h3fff;
    res(last);
    cmd(8'haf, 8'h10);
    pcm[1] <= 16'h0123;
    repeat (2 * FC) @(posedge clk);
    res(last);
    check({15'h0000, meter_running}, 16'h0000);
    $display("test single shot and disable done");
    close_out();
  end
endmodule
